// ===== verilog/uscr_pkg.sv
// Constants for the USB control and status register group.
// Assumes byte-wide registers reached over the parallel local bus.
package uscr_pkg;
	localparam logic [7:0] USCR_OFF_CTL_LOW = 8'h18;
	localparam logic [7:0] USCR_OFF_CTL_HIGH = 8'h19;
	localparam logic [7:0] USCR_OFF_FRAME_LOW = 8'h1A;
	localparam logic [7:0] USCR_OFF_FRAME_HIGH = 8'h1B;
	localparam logic [7:0] USCR_OFF_REVISION = 8'h23;
	localparam int USCR_LOW_RSVD_HI = 7;
	localparam int USCR_LOW_RSVD_LO = 6;
	localparam int USCR_LOW_WAKE_EN = 5;
	localparam int USCR_LOW_RSVD4 = 4;
	localparam int USCR_LOW_CONNECT = 3;
	localparam int USCR_LOW_IO_WAKE = 1;
	localparam int USCR_HIGH_RESUME = 3;
	localparam int USCR_HIGH_HS = 2;
	localparam int USCR_HIGH_FS = 1;
	localparam int USCR_HIGH_VBUS = 0;
	localparam logic [1:0] USCR_RST_RSVD76 = 2'h3;
	localparam logic USCR_RST_WAKE_EN = 1'b1;
	localparam logic USCR_RST_RSVD4 = 1'b0;
	localparam logic USCR_RST_CONNECT = 1'b0;
	localparam logic USCR_RST_IO_WAKE = 1'b0;
	localparam logic [10:0] USCR_RST_FRAME = 11'h000;
	// Revision code in BCD; the value is arbitrary.
	localparam logic [7:0] USCR_REVISION = 8'h12;
	localparam int USCR_SYNC_W = 20;
endpackage

// ===== verilog/uscr_sync.sv
// Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes each bit is a slow level; multi-bit words must be held stable by the sender.
`timescale 1ns/1ns
module uscr_sync #(
	parameter int W = 1
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_async,
	input wire logic [W-1:0] i_rst_val,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// Bits are stored relative to their reset level, so the flops clear to zero yet report the idle level.
	// The reset value is a constant at every instance, so flops still load a constant.
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async ^ i_rst_val;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q ^ i_rst_val;
endmodule // uscr_sync

// ===== verilog/uscr_regs.sv
// USB control and status register group behind the local parallel bus.
// Assumes core USB logic on i_ref_clk supplies speed, bus activity and SOF results.
`timescale 1ns/1ns
module uscr_regs
	import uscr_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	input wire logic i_vbus,
	input wire logic i_bus_activity,
	input wire logic i_high_speed,
	input wire logic i_full_speed,
	input wire logic i_remote_wakeup_en,
	input wire logic i_sof_valid,
	input wire logic i_sof_error,
	input wire logic [10:0] i_sof_frame,
	output logic o_connect,
	output logic o_wakeup_detect,
	output logic o_remote_wakeup,
	output logic o_resume_start
);
	logic [USCR_SYNC_W-1:0] sync_out;
	logic cs_n_s;
	logic rd_n_s;
	logic wr_n_s;
	logic vbus_s;
	logic [7:0] addr_s;
	logic [7:0] data_s;

	// Strobes reset to their idle high level through the inversion mask.
	uscr_sync #(.W(USCR_SYNC_W)) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_async({i_cs_n, i_rd_n, i_wr_n, i_vbus, i_addr, i_data}),
		.i_rst_val({3'h7, 17'h00000}),
		.o_sync(sync_out)
	);
	assign {cs_n_s, rd_n_s, wr_n_s, vbus_s, addr_s, data_s} = sync_out;

	logic wr_n_prev_q, wr_n_prev_d;
	logic cs_n_prev_q, cs_n_prev_d;
	logic [1:0] rsvd76_q, rsvd76_d;
	logic wake_en_q, wake_en_d;
	logic rsvd4_q, rsvd4_d;
	logic connect_q, connect_d;
	logic io_wake_q, io_wake_d;
	logic [10:0] frame_q, frame_d;
	logic [7:0] rdata_q, rdata_d;
	logic oe_q, oe_d;
	logic wakeup_q, wakeup_d;
	logic rwake_q, rwake_d;
	logic resume_q, resume_d;
	logic wr_strobe;
	logic cs_fall;
	logic rd_active;

	// A write lands on the trailing edge of the synchronised write strobe, once address and data settled.
	assign wr_strobe = !wr_n_prev_q && wr_n_s && !cs_n_s;
	assign cs_fall = cs_n_prev_q && !cs_n_s;
	assign rd_active = !cs_n_s && !rd_n_s;

	always_comb begin
		wr_n_prev_d = wr_n_s;
		cs_n_prev_d = cs_n_s;
		rsvd76_d = rsvd76_q;
		wake_en_d = wake_en_q;
		rsvd4_d = rsvd4_q;
		connect_d = connect_q;
		io_wake_d = io_wake_q;
		frame_d = frame_q;
		resume_d = 1'b0;
		if (wr_strobe && addr_s == USCR_OFF_CTL_LOW) begin
			rsvd76_d = data_s[USCR_LOW_RSVD_HI:USCR_LOW_RSVD_LO];
			wake_en_d = data_s[USCR_LOW_WAKE_EN];
			rsvd4_d = data_s[USCR_LOW_RSVD4];
			connect_d = data_s[USCR_LOW_CONNECT];
			io_wake_d = data_s[USCR_LOW_IO_WAKE];
		end
		// Resume is a one-cycle strobe; no bit is stored, so it cannot be read back.
		if (wr_strobe && addr_s == USCR_OFF_CTL_HIGH && data_s[USCR_HIGH_RESUME] && i_remote_wakeup_en) begin
			resume_d = 1'b1;
		end
		if (i_sof_valid && !i_sof_error) begin
			frame_d = i_sof_frame;
		end
		wakeup_d = wake_en_q && i_bus_activity;
		rwake_d = io_wake_q && cs_fall;
		oe_d = rd_active;
		rdata_d = 8'h00;
		if (rd_active) begin
			unique case (addr_s)
				USCR_OFF_CTL_LOW: begin
					rdata_d = {rsvd76_q, wake_en_q, rsvd4_q, connect_q, 1'b0, io_wake_q, 1'b0};
				end
				USCR_OFF_CTL_HIGH: begin
					rdata_d = {4'h0, 1'b0, i_high_speed, i_full_speed, vbus_s};
				end
				USCR_OFF_FRAME_LOW: begin
					rdata_d = frame_q[7:0];
				end
				USCR_OFF_FRAME_HIGH: begin
					rdata_d = {5'h00, frame_q[10:8]};
				end
				USCR_OFF_REVISION: begin
					rdata_d = USCR_REVISION;
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_n_prev_q <= 1'b1;
			cs_n_prev_q <= 1'b1;
			rsvd76_q <= USCR_RST_RSVD76;
			wake_en_q <= USCR_RST_WAKE_EN;
			rsvd4_q <= USCR_RST_RSVD4;
			connect_q <= USCR_RST_CONNECT;
			io_wake_q <= USCR_RST_IO_WAKE;
			frame_q <= USCR_RST_FRAME;
			rdata_q <= 8'h00;
			oe_q <= 1'b0;
			wakeup_q <= 1'b0;
			rwake_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			wr_n_prev_q <= wr_n_prev_d;
			cs_n_prev_q <= cs_n_prev_d;
			rsvd76_q <= rsvd76_d;
			wake_en_q <= wake_en_d;
			rsvd4_q <= rsvd4_d;
			connect_q <= connect_d;
			io_wake_q <= io_wake_d;
			frame_q <= frame_d;
			rdata_q <= rdata_d;
			oe_q <= oe_d;
			wakeup_q <= wakeup_d;
			rwake_q <= rwake_d;
			resume_q <= resume_d;
		end
	end

	assign o_data = rdata_q;
	assign o_data_oe = oe_q;
	assign o_connect = connect_q;
	assign o_wakeup_detect = wakeup_q;
	assign o_remote_wakeup = rwake_q;
	assign o_resume_start = resume_q;

	property p_rev_read;
		@(posedge i_ref_clk) disable iff (i_rst) (rd_active && addr_s == USCR_OFF_REVISION) |=> (o_data == USCR_REVISION);
	endproperty
	a_rev_read: assert property (p_rev_read) else $error("revision read wrong");

	property p_wake_detect;
		@(posedge i_ref_clk) disable iff (i_rst) ##1 (o_wakeup_detect == ($past(wake_en_q) && $past(i_bus_activity)));
	endproperty
	a_wake_detect: assert property (p_wake_detect) else $error("wakeup detect mismatch");

	property p_connect_write;
		@(posedge i_ref_clk) disable iff (i_rst) (wr_strobe && addr_s == USCR_OFF_CTL_LOW) |=> (o_connect == $past(data_s[3]));
	endproperty
	a_connect_write: assert property (p_connect_write) else $error("connect bit not written");

	property p_io_wake;
		@(posedge i_ref_clk) disable iff (i_rst) cs_fall |=> (o_remote_wakeup == $past(io_wake_q));
	endproperty
	a_io_wake: assert property (p_io_wake) else $error("chip select wakeup wrong");

	property p_resume_cause;
		@(posedge i_ref_clk) disable iff (i_rst) o_resume_start |-> $past(wr_strobe && addr_s == USCR_OFF_CTL_HIGH && data_s[3] && i_remote_wakeup_en);
	endproperty
	a_resume_cause: assert property (p_resume_cause) else $error("resume without cause");

	property p_resume_pulse;
		@(posedge i_ref_clk) disable iff (i_rst) o_resume_start |=> !o_resume_start;
	endproperty
	a_resume_pulse: assert property (p_resume_pulse) else $error("resume not self clearing");

	property p_high_read;
		@(posedge i_ref_clk) disable iff (i_rst) (rd_active && addr_s == USCR_OFF_CTL_HIGH) |=>
			(o_data[3] == 1'b0 && o_data[2] == $past(i_high_speed) && o_data[1] == $past(i_full_speed) && o_data[0] == $past(vbus_s));
	endproperty
	a_high_read: assert property (p_high_read) else $error("control high readback wrong");

	property p_frame_load;
		@(posedge i_ref_clk) disable iff (i_rst) (i_sof_valid && !i_sof_error) |=> (frame_q == $past(i_sof_frame));
	endproperty
	a_frame_load: assert property (p_frame_load) else $error("frame not loaded");

	property p_frame_hold;
		@(posedge i_ref_clk) disable iff (i_rst) !(i_sof_valid && !i_sof_error) |=> $stable(frame_q);
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("frame changed without good SOF");

	property p_frame_high_read;
		@(posedge i_ref_clk) disable iff (i_rst) (rd_active && addr_s == USCR_OFF_FRAME_HIGH) |=> (o_data[7:3] == 5'h00);
	endproperty
	a_frame_high_read: assert property (p_frame_high_read) else $error("frame high upper bits set");

	c_resume: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_resume_start);
	c_rwake: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_remote_wakeup);
	c_connect: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_connect));
	c_frame: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_sof_valid && i_sof_error);
endmodule // uscr_regs

// ===== tb/uscr_cpu.sv
// Local processor model for the parallel register bus.
// Assumes the bench calls acc one access at a time.
`timescale 1ns/1ns
module uscr_cpu (
	input wire logic i_ref_clk,
	input wire logic [7:0] i_data,
	input wire logic i_data_oe,
	output logic o_cs_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic [7:0] o_addr,
	output logic [7:0] o_data
);
	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_addr = 8'h00;
		o_data = 8'h00;
	end
	// Four cycles low and high, one over the minimum, so a slow answer still lands.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge i_ref_clk);
		o_cs_n = 1'b0;
		o_rd_n = w;
		o_wr_n = !w;
		o_addr = a;
		o_data = d;
		repeat (4) @(negedge i_ref_clk);
		q = i_data_oe ? i_data : 8'hXX;
		// The strobe rises a cycle ahead of chip select, because a write commits on that rise while select is low.
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		@(negedge i_ref_clk);
		o_cs_n = 1'b1;
		repeat (2) @(negedge i_ref_clk);
		// Hold time is over, so the lines stop showing the old value.
		o_addr = ~a;
		o_data = ~d;
	endtask
endmodule // uscr_cpu

// ===== tb/uscr_regs_test.sv
// Self-checking bench for the USB control and status registers.
// Assumes the processor model owns the bus pins; the bench drives the core side.
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module uscr_regs_test;
	import uscr_pkg::*;
	logic i_ref_clk, i_rst, cs_n, rd_n, wr_n, vbus, act, hs, fs, rwe, sofv, sofe, oe, conn, wk, rw, rs;
	logic [7:0] addr, wdat, rdat, got, ex;
	logic [10:0] frm, fold;
	logic [7:0] exq[$];
	int num_errors = 0;
	int tests_run = 0;
	int nwk = 0;
	int nrw = 0;
	int nrs = 0;
	int seed = 93614;
	event rdone;
	uscr_regs DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
		.i_addr(addr), .i_data(wdat), .o_data(rdat), .o_data_oe(oe), .i_vbus(vbus),
		.i_bus_activity(act), .i_high_speed(hs), .i_full_speed(fs), .i_remote_wakeup_en(rwe),
		.i_sof_valid(sofv), .i_sof_error(sofe), .i_sof_frame(frm), .o_connect(conn),
		.o_wakeup_detect(wk), .o_remote_wakeup(rw), .o_resume_start(rs));
	uscr_cpu u_cpu (.i_ref_clk(i_ref_clk), .i_data(rdat), .i_data_oe(oe), .o_cs_n(cs_n), .o_rd_n(rd_n),
		.o_wr_n(wr_n), .o_addr(addr), .o_data(wdat));
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	// Pulses are counted at the falling edge, where the registered outputs have settled.
	always @(negedge i_ref_clk) begin
		nwk += (wk === 1'b1);
		nrw += (rw === 1'b1);
		nrs += (rs === 1'b1);
	end
	always @(rdone) begin
		ex = exq.pop_front();
		`CHK("read data", ex, got)
	end
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exq.push_back(e);
		u_cpu.acc(1'b0, a, 8'h00, got);
		->rdone;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_cpu.acc(1'b1, a, d, q);
		repeat (2) @(negedge i_ref_clk);
	endtask
	task automatic pulse_act;
		nwk = 0;
		act = 1'b1;
		@(negedge i_ref_clk);
		act = 1'b0;
		repeat (3) @(negedge i_ref_clk);
	endtask
	task results;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#2000000;
		num_errors++;
		results;
	end
	initial begin
		{i_rst, vbus, act, hs, fs, rwe, sofv, sofe, frm} = {1'b1, 18'h00000};
		repeat (12) @(negedge i_ref_clk);
		i_rst = 1'b0;
		rd(USCR_OFF_CTL_LOW, 8'hE0);
		rd(USCR_OFF_CTL_HIGH, 8'h00);
		rd(USCR_OFF_FRAME_LOW, 8'h00);
		rd(USCR_OFF_FRAME_HIGH, 8'h00);
		wr(USCR_OFF_REVISION, ~USCR_REVISION);
		rd(USCR_OFF_REVISION, USCR_REVISION);
		rd(8'h40, 8'h00);
		$display("test reset done");
		wr(USCR_OFF_CTL_LOW, 8'h0F);
		rd(USCR_OFF_CTL_LOW, 8'h0A);
		`CHK("connect", 1'b1, conn)
		pulse_act();
		`CHK("wake off", 0, nwk)
		nrw = 0;
		rd(USCR_OFF_CTL_LOW, 8'h0A);
		`CHK("cs wake", 1, nrw)
		wr(USCR_OFF_CTL_LOW, 8'h20);
		`CHK("disconnect", 1'b0, conn)
		nrw = 0;
		rd(USCR_OFF_CTL_LOW, 8'h20);
		`CHK("cs no wake", 0, nrw)
		pulse_act();
		`CHK("wake on", 1, nwk)
		$display("test control done");
		repeat (4) begin
			{vbus, hs, fs} = 3'($random(seed));
			repeat (3) @(negedge i_ref_clk);
			rd(USCR_OFF_CTL_HIGH, {5'h00, hs, fs, vbus});
		end
		$display("test status done");
		nrs = 0;
		wr(USCR_OFF_CTL_HIGH, 8'h08);
		`CHK("resume off", 0, nrs)
		rwe = 1'b1;
		wr(USCR_OFF_CTL_LOW, 8'h22);
		wr(USCR_OFF_CTL_HIGH, 8'hFF);
		`CHK("resume on", 1, nrs)
		rd(USCR_OFF_CTL_HIGH, {5'h00, hs, fs, vbus});
		$display("test resume done");
		repeat (3) begin
			fold = frm;
			frm = 11'($random(seed));
			{sofv, sofe} = 2'h3;
			@(negedge i_ref_clk);
			{sofv, sofe} = 2'h0;
			rd(USCR_OFF_FRAME_LOW, fold[7:0]);
			rd(USCR_OFF_FRAME_HIGH, {5'h00, fold[10:8]});
			sofv = 1'b1;
			@(negedge i_ref_clk);
			sofv = 1'b0;
			wr(USCR_OFF_FRAME_LOW, ~frm[7:0]);
			rd(USCR_OFF_FRAME_LOW, frm[7:0]);
			rd(USCR_OFF_FRAME_HIGH, {5'h00, frm[10:8]});
		end
		$display("test frame done");
		wr(USCR_OFF_CTL_LOW, 8'h28);
		`CHK("connect before reset", 1'b1, conn)
		@(negedge i_ref_clk);
		i_rst = 1'b1;
		repeat (3) @(negedge i_ref_clk);
		i_rst = 1'b0;
		`CHK("connect after reset", 1'b0, conn)
		rd(USCR_OFF_CTL_LOW, 8'hE0);
		rd(USCR_OFF_FRAME_LOW, 8'h00);
		rd(USCR_OFF_FRAME_HIGH, 8'h00);
		$display("test second reset done");
		results;
	end
endmodule // uscr_regs_test
